// File: rtl/dag_consts.vh
// Constants for the DSP effective-address generator: register indices,
// field positions, reset values and request mode codes.
// Assumes it is included by bare name from the design files under rtl/.
//
// Contract
// - Dual prefetch pointers only W8 to W11
// - W8/W9 to X unit, W10/W11 to Y
// - Indexed dual mode only on W9, W11
// - Dual modes: indirect, post-modify 2/4/6, indexed
// - One circular buffer each in X, Y
// - One-way wrap; power-of-two lengths wrap both ways
// - Length from 16-bit start and end registers
// - Y circular addresses keep bit zero clear
// - X circular needs select not 1111, bit15
// - Y circular needs select not 1111, bit14
// - Crossings detected beyond boundary, not only equal
// - Write back wrap only for pre/post modify
// - Bit reversal only X unit, writes only
// - Reversal needs select, enable, pre/post increment
// - Modifier pivot bits 14:0, enable bit 15
// - Reversal word-sized, modifier scaled, bit zero clear
// - Byte or other modes give normal addresses
// - Reversal adds reversed modifier, ignores normal step
// - Reversal beats circular on data writes
`ifndef DAG_CONSTS_VH
`define DAG_CONSTS_VH

// Register indices on the plain register port
`define DAG_REG_X_CIRC_START 3'h0
`define DAG_REG_X_CIRC_END 3'h1
`define DAG_REG_Y_CIRC_START 3'h2
`define DAG_REG_Y_CIRC_END 3'h3
`define DAG_REG_CIRC_REV_CTRL 3'h4
`define DAG_REG_REV_MODIFIER 3'h5

// Reset values
`define DAG_RST_BOUND 16'h0000
`define DAG_RST_CTRL 16'h0000
`define DAG_RST_MODIFIER 16'h0000

// Control register fields
`define DAG_CTRL_X_SEL_LSB 0
`define DAG_CTRL_Y_SEL_LSB 4
`define DAG_CTRL_REV_SEL_LSB 8
`define DAG_CTRL_X_EN_BIT 15
`define DAG_CTRL_Y_EN_BIT 14
`define DAG_SEL_OFF 4'hF

// Modifier register fields
`define DAG_MOD_REV_EN_BIT 15

// Request mode codes
`define DAG_MODE_INDIRECT 2'h0
`define DAG_MODE_POST 2'h1
`define DAG_MODE_PRE 2'h2
`define DAG_MODE_INDEXED 2'h3

// Pointer numbers that matter to the dual-operand class
`define DAG_W8 4'h8
`define DAG_W9 4'h9
`define DAG_W10 4'hA
`define DAG_W11 4'hB

`endif

// File: rtl/dag_core.v
// Effective-address generator for X and Y data spaces: circular buffers,
// bit-reversed writes and the dual-operand pointer checks.
// Assumes the decoder presents one request per cycle with the pointer value
// already read from the working register file, on the same sys_clk.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "dag_consts.vh"
module dag_core
(
  // Clock and synchronous reset
  input wire sys_clk,
  input wire sys_rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Request from instruction decode
  input wire req_valid,
  input wire req_dual,
  input wire req_write,
  input wire req_byte,
  input wire [1:0] req_mode,
  input wire [3:0] req_wn,
  input wire [15:0] req_ptr,
  input wire [15:0] req_offs,
  // Answer toward the data address buses
  output reg ea_valid,
  output reg ea_space_y,
  output reg [15:0] ea_addr,
  output reg ea_error,
  // Pointer write-back toward the register file
  output reg wb_valid,
  output reg [3:0] wb_wn,
  output reg [15:0] wb_value
);

  // Software-visible registers
  reg [15:0] x_circular_start_q;
  reg [15:0] x_circular_end_q;
  reg [15:0] y_circular_start_q;
  reg [15:0] y_circular_end_q;
  reg [15:0] circular_reverse_control_q;
  reg [15:0] reverse_modifier_q;

  // Control fields, named for the logic that uses them
  wire [3:0] x_circ_pointer_select;
  wire [3:0] y_circ_pointer_select;
  wire [3:0] reverse_pointer_select;
  wire x_circ_enable;
  wire y_circ_enable;
  wire reverse_enable;
  wire [14:0] reverse_pivot;

  assign x_circ_pointer_select = circular_reverse_control_q[`DAG_CTRL_X_SEL_LSB +: 4];
  assign y_circ_pointer_select = circular_reverse_control_q[`DAG_CTRL_Y_SEL_LSB +: 4];
  assign reverse_pointer_select = circular_reverse_control_q[`DAG_CTRL_REV_SEL_LSB +: 4];
  assign x_circ_enable = circular_reverse_control_q[`DAG_CTRL_X_EN_BIT];
  assign y_circ_enable = circular_reverse_control_q[`DAG_CTRL_Y_EN_BIT];
  // Pivot in the low fifteen bits, enable on top.
  // A modifier write is used from the next request on, with no interlock:
  // software must leave a gap before a reversed access through the pointer.
  assign reverse_enable = reverse_modifier_q[`DAG_MOD_REV_EN_BIT];
  assign reverse_pivot = reverse_modifier_q[14:0];

  // Mirror a 16-bit word end for end
  // Lets a plain adder serve as the reverse-carry adder further down
  function [15:0] dag_mirror;
    input [15:0] v;
    integer i;
    begin
      dag_mirror = 16'h0000;
      for (i = 0; i < 16; i = i + 1)
      begin
        dag_mirror[i] = v[15 - i];
      end
    end
  endfunction

  // Register writes; one register per index, unmapped indices ignored
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      x_circular_start_q <= `DAG_RST_BOUND;
      x_circular_end_q <= `DAG_RST_BOUND;
      y_circular_start_q <= `DAG_RST_BOUND;
      y_circular_end_q <= `DAG_RST_BOUND;
      circular_reverse_control_q <= `DAG_RST_CTRL;
      reverse_modifier_q <= `DAG_RST_MODIFIER;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `DAG_REG_X_CIRC_START: x_circular_start_q <= reg_wdata;
        `DAG_REG_X_CIRC_END: x_circular_end_q <= reg_wdata;
        `DAG_REG_Y_CIRC_START: y_circular_start_q <= reg_wdata;
        `DAG_REG_Y_CIRC_END: y_circular_end_q <= reg_wdata;
        `DAG_REG_CIRC_REV_CTRL: circular_reverse_control_q <= reg_wdata;
        `DAG_REG_REV_MODIFIER: reverse_modifier_q <= reg_wdata;
        default:
        begin
          // Unmapped index: write is dropped
        end
      endcase
    end
  end

  // Read data is registered, valid the cycle after the strobe only
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `DAG_REG_X_CIRC_START: reg_rdata <= x_circular_start_q;
        `DAG_REG_X_CIRC_END: reg_rdata <= x_circular_end_q;
        `DAG_REG_Y_CIRC_START: reg_rdata <= y_circular_start_q;
        `DAG_REG_Y_CIRC_END: reg_rdata <= y_circular_end_q;
        `DAG_REG_CIRC_REV_CTRL: reg_rdata <= circular_reverse_control_q;
        `DAG_REG_REV_MODIFIER: reg_rdata <= reverse_modifier_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      // Data stands for one cycle only
      reg_rdata <= 16'h0000;
    end
  end

  // Request decode, space routing and legality
  wire is_dual_ptr;
  wire to_y_space;
  wire dual_bad_ptr;
  wire dual_bad_index;
  wire dual_bad_step;
  wire dual_bad_write;
  wire req_bad;
  wire [15:0] step_abs;
  wire step_neg;

  // Only W8..W11 may serve as prefetch pointers
  assign is_dual_ptr = (req_wn == `DAG_W8) || (req_wn == `DAG_W9) ||
    (req_wn == `DAG_W10) || (req_wn == `DAG_W11);
  assign dual_bad_ptr = req_dual && !is_dual_ptr;
  // W8/W9 always go to X, W10/W11 to the Y unit only on a dual request
  assign to_y_space = req_dual && ((req_wn == `DAG_W10) || (req_wn == `DAG_W11));
  // Indexed form only through W9 or W11 in the dual class
  assign dual_bad_index = req_dual && (req_mode == `DAG_MODE_INDEXED) &&
    (req_wn != `DAG_W9) && (req_wn != `DAG_W11);
  // The sign of the step gives the direction of travel for wrap checks
  assign step_neg = req_offs[15];
  assign step_abs = step_neg ? (16'h0000 - req_offs) : req_offs;
  // Post-modify amounts limited to 2, 4 or 6; pre-modify absent in the class
  assign dual_bad_step = req_dual && (((req_mode == `DAG_MODE_POST) &&
    (step_abs != 16'h0002) && (step_abs != 16'h0004) && (step_abs != 16'h0006)) ||
    (req_mode == `DAG_MODE_PRE));
  // Dual prefetch is a read-only path
  assign dual_bad_write = req_dual && req_write;
  assign req_bad = dual_bad_ptr || dual_bad_index || dual_bad_step || dual_bad_write;

  // Circular buffer selection for the space in use
  wire x_circ_on;
  wire y_circ_on;
  wire circ_hit;
  wire [15:0] buf_start;
  wire [15:0] buf_end;
  wire [16:0] buf_len;
  wire buf_pow2;

  // X buffer live only when its select is real and its enable set
  assign x_circ_on = x_circ_enable && (x_circ_pointer_select != `DAG_SEL_OFF);
  // Y buffer likewise, on its own field and bit
  assign y_circ_on = y_circ_enable && (y_circ_pointer_select != `DAG_SEL_OFF);
  // One buffer per space; the space picks which pair of bounds applies
  assign circ_hit = to_y_space ? (y_circ_on && (req_wn == y_circ_pointer_select)) :
    (x_circ_on && (req_wn == x_circ_pointer_select));
  assign buf_start = to_y_space ? y_circular_start_q : x_circular_start_q;
  assign buf_end = to_y_space ? y_circular_end_q : x_circular_end_q;
  // Length in bytes from the two 16-bit bounds, up to 64 Kbytes
  assign buf_len = {1'b0, buf_end} - {1'b0, buf_start} + 17'h00001;
  // Power-of-two lengths may be walked both ways, so both bounds apply
  assign buf_pow2 = ((buf_len & (buf_len - 17'h00001)) == 17'h00000);

  // Raw modified address, kept wide so overshoot past 0xFFFF is visible
  wire [17:0] raw_sum;
  wire [15:0] mod_src;
  wire do_modify;
  wire going_up;
  wire going_down;
  wire over_top;
  wire under_bottom;
  reg [17:0] wrapped;
  wire [15:0] circ_addr;

  // Indirect form has no change; others add offset or signed step
  assign do_modify = (req_mode != `DAG_MODE_INDIRECT);
  assign mod_src = do_modify ? req_offs : 16'h0000;
  assign raw_sum = {2'b00, req_ptr} + {{2{mod_src[15]}}, mod_src};
  // Power-of-two buffers check both bounds; others only the travel side
  assign going_up = !step_neg || buf_pow2;
  assign going_down = step_neg || buf_pow2;
  // Beyond the bound counts as crossing, so large steps still wrap
  assign over_top = going_up && ($signed(raw_sum) > $signed({2'b00, buf_end}));
  assign under_bottom = going_down &&
    ($signed(raw_sum) < $signed({2'b00, buf_start}));

  // Fold the raw address back into the buffer
  always @*
  begin
    wrapped = raw_sum;
    if (circ_hit && do_modify)
    begin
      if (over_top)
      begin
        wrapped = raw_sum - {1'b0, buf_len};
      end
      else if (under_bottom)
      begin
        wrapped = raw_sum + {1'b0, buf_len};
      end
    end
  end

  // Y space always word aligned; X keeps byte resolution
  // Forcing bit zero here is free and keeps odd pointers off the Y bus
  assign circ_addr = to_y_space ? {wrapped[15:1], 1'b0} : wrapped[15:0];

  // Bit-reversed path
  wire rev_hit;
  wire [15:0] rev_step;
  wire [15:0] rev_sum;
  wire [15:0] rev_addr;

  // Needs select, enable, word write via X, incrementing pre or post mode
  assign rev_hit = reverse_enable && (reverse_pointer_select != `DAG_SEL_OFF) &&
    (req_wn == reverse_pointer_select) && req_write && !req_byte && !to_y_space &&
    ((req_mode == `DAG_MODE_PRE) || (req_mode == `DAG_MODE_POST)) &&
    !step_neg && (req_offs != 16'h0000);
  // Modifier counts words; shift to byte units
  assign rev_step = {reverse_pivot, 1'b0};
  // Carry runs from MSB toward LSB: mirror, add, mirror back
  assign rev_sum = dag_mirror(dag_mirror(req_ptr) + dag_mirror(rev_step));
  // Bit zero of a reversed address is always clear
  assign rev_addr = {rev_sum[15:1], 1'b0};

  // Final selection of address and write-back
  reg [15:0] ea_d;
  reg wb_en_d;
  reg [15:0] wb_value_d;

  // Reversal wins over circular; normal step ignored when reversing
  // A byte write or any other mode falls through to the normal path
  always @*
  begin
    ea_d = req_ptr;
    wb_en_d = 1'b0;
    wb_value_d = req_ptr;
    if (rev_hit)
    begin
      // Pointer and result kept in normal order, only modifier reversed
      wb_en_d = 1'b1;
      wb_value_d = rev_addr;
      if (req_mode == `DAG_MODE_PRE)
      begin
        ea_d = rev_addr;
      end
      else
      begin
        ea_d = {req_ptr[15:1], 1'b0};
      end
    end
    else
    begin
      case (req_mode)
        `DAG_MODE_INDIRECT:
        begin
          ea_d = to_y_space ? {req_ptr[15:1], 1'b0} : req_ptr;
        end
        `DAG_MODE_POST:
        begin
          // Access at old pointer, wrapped value written back
          ea_d = to_y_space ? {req_ptr[15:1], 1'b0} : req_ptr;
          wb_en_d = 1'b1;
          wb_value_d = circ_addr;
        end
        `DAG_MODE_PRE:
        begin
          ea_d = circ_addr;
          wb_en_d = 1'b1;
          wb_value_d = circ_addr;
        end
        `DAG_MODE_INDEXED:
        begin
          // Correction applies to the access, pointer left alone
          ea_d = circ_addr;
          wb_en_d = 1'b0;
        end
        default:
        begin
          ea_d = req_ptr;
        end
      endcase
    end
  end

  // Answer register: one request in, one answer out a cycle later.
  // Illegal requests still answer, flagged, with no pointer update so the
  // register file is never corrupted by a decode fault.
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ea_valid <= 1'b0;
      ea_space_y <= 1'b0;
      ea_addr <= 16'h0000;
      ea_error <= 1'b0;
      wb_valid <= 1'b0;
      wb_wn <= 4'h0;
      wb_value <= 16'h0000;
    end
    else if (req_valid)
    begin
      ea_valid <= 1'b1;
      ea_space_y <= to_y_space;
      ea_addr <= req_bad ? 16'h0000 : ea_d;
      ea_error <= req_bad;
      wb_valid <= wb_en_d && !req_bad;
      wb_wn <= req_wn;
      wb_value <= wb_value_d;
    end
    else
    begin
      // Pulses drop back; data holds its last value
      ea_valid <= 1'b0;
      ea_error <= 1'b0;
      wb_valid <= 1'b0;
    end
  end

endmodule

// File: tb/dag_rf_model.sv
// Working register file model on the decode side of the address generator.
// Assumes write-back pulses arrive on sys_clk and the bench preloads pointers.
`timescale 1ns/1ns
module dag_rf_model
(
  // Clock
  input wire sys_clk,
  // Bench preload
  input wire set_en,
  input wire [3:0] set_wn,
  input wire [15:0] set_val,
  // Design side
  input wire wb_valid,
  input wire [3:0] wb_wn,
  input wire [15:0] wb_value,
  input wire [3:0] req_wn,
  output wire [15:0] req_ptr
);
  // Sixteen pointers, read combinationally like a register file port
  reg [15:0] rf [0:15];
  assign req_ptr = rf[req_wn];
  // Write-back wins; the bench never preloads in a write-back cycle
  always @(posedge sys_clk)
  begin
    if (wb_valid)
      rf[wb_wn] <= wb_value;
    else if (set_en)
      rf[set_wn] <= set_val;
  end
endmodule

// File: tb/dag_core_asserts.sv
// Port checks for the address generator.
// Assumes one sys_clk domain with synchronous active-high sys_rst.
`timescale 1ns/1ns
module dag_core_asserts
(
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Request and answer
  input wire req_valid,
  input wire req_dual,
  input wire [1:0] req_mode,
  input wire [3:0] req_wn,
  input wire [15:0] req_ptr,
  input wire ea_valid,
  input wire ea_space_y,
  input wire [15:0] ea_addr,
  input wire ea_error,
  input wire wb_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Answer comes exactly one cycle after each request, never otherwise
  property p_ea_pulse; req_valid |=> ea_valid; endproperty
  a_ea_pulse: assert property (p_ea_pulse) else $error("answer missing");
  property p_ea_quiet; !req_valid |=> !ea_valid && !wb_valid; endproperty
  a_ea_quiet: assert property (p_ea_quiet) else $error("stray answer");
  property p_err_zero; ea_error |-> ea_addr == 16'h0000 && !wb_valid; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused request leaked");
  property p_dual_set;
    req_valid && req_dual && (req_wn < 4'h8 || req_wn > 4'hB) |=> ea_error;
  endproperty
  a_dual_set: assert property (p_dual_set) else $error("bad pointer accepted");
  property p_idx_only;
    req_valid && req_dual && req_mode == 2'h3 && !req_wn[0] |=> ea_error;
  endproperty
  a_idx_only: assert property (p_idx_only) else $error("indexed on wrong pointer");
  property p_x_route; req_valid && (!req_dual || req_wn[3:1] == 3'h4) |=> !ea_space_y; endproperty
  a_x_route: assert property (p_x_route) else $error("wrong unit");
  property p_y_lsb; ea_valid && ea_space_y |-> !ea_addr[0]; endproperty
  a_y_lsb: assert property (p_y_lsb) else $error("odd Y address");
  property p_plain;
    req_valid && !req_dual && req_mode == 2'h0 |=> ea_addr == $past(req_ptr) && !wb_valid;
  endproperty
  a_plain: assert property (p_plain) else $error("indirect address altered");
  property p_rd_idle; !reg_rd || reg_addr > 3'h5 |=> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_wr_rd;
    reg_wr && reg_addr < 3'h6 ##1 reg_rd && reg_addr == $past(reg_addr)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("register readback wrong");
endmodule
bind dag_core dag_core_asserts u_chk
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
  .req_dual(req_dual), .req_mode(req_mode), .req_wn(req_wn), .req_ptr(req_ptr),
  .ea_valid(ea_valid), .ea_space_y(ea_space_y), .ea_addr(ea_addr), .ea_error(ea_error),
  .wb_valid(wb_valid)
);

// File: tb/testbench.sv
// Self-checking bench for the address generator with a scoreboard model.
// Assumes dag_core, dag_rf_model and the constants header are compiled in.
`timescale 1ns/1ns
`include "dag_consts.vh"
module testbench;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [2:0] reg_addr = 3'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg req_valid = 1'b0;
  reg req_dual = 1'b0;
  reg req_write = 1'b0;
  reg req_byte = 1'b0;
  reg [1:0] req_mode = 2'h0;
  reg [3:0] req_wn = 4'h0;
  reg [15:0] req_offs = 16'h0000;
  reg set_en = 1'b0;
  reg [3:0] set_wn = 4'h0;
  reg [15:0] set_val = 16'h0000;
  wire [15:0] reg_rdata, req_ptr, ea_addr, wb_value;
  wire ea_valid, ea_space_y, ea_error, wb_valid;
  wire [3:0] wb_wn;
  integer err_count = 0, tests_run = 0, cyc = 0, i;
  // Shadow registers and pointers of the scoreboard
  reg [15:0] rg [0:7];
  reg [15:0] ptrs [0:15];
  dag_core dut
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_dual(req_dual), .req_write(req_write), .req_byte(req_byte), .req_mode(req_mode),
    .req_wn(req_wn), .req_ptr(req_ptr), .req_offs(req_offs), .ea_valid(ea_valid),
    .ea_space_y(ea_space_y), .ea_addr(ea_addr), .ea_error(ea_error), .wb_valid(wb_valid),
    .wb_wn(wb_wn), .wb_value(wb_value)
  );
  dag_rf_model u_rf
  (
    .sys_clk(sys_clk), .set_en(set_en), .set_wn(set_wn), .set_val(set_val),
    .wb_valid(wb_valid), .wb_wn(wb_wn), .wb_value(wb_value), .req_wn(req_wn),
    .req_ptr(req_ptr)
  );
  // 20 MHz clock
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  task complete_run;
  begin
    $display("Mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // One comparison; flags arrive zero-extended, so X still mismatches
  task chk(input [15:0] e, input [15:0] g);
  begin
    tests_run = tests_run + 1;
    if (e !== g)
    begin
      err_count = err_count + 1;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  end
  endtask
  // Register read data against the shadow copy
  task chk_rd(input [15:0] e, input [15:0] g);
  begin
    chk(e, g);
  end
  endtask
  // Pointer write-back against the model's new pointer
  task chk_wb(input [15:0] e, input [15:0] g);
  begin
    chk(e, g);
  end
  endtask
  // Write then read back with the strobes back to back, no idle cycle
  task wr_rd(input [2:0] a, input [15:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    if (a < 3'h6)
      rg[a] = d;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_rd(a < 3'h6 ? rg[a] : 16'h0000, reg_rdata);
  end
  endtask
  task wr_reg(input [2:0] a, input [15:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a < 3'h6)
      rg[a] = d;
  end
  endtask
  // Read data stands only in the cycle after the strobe
  task rd_chk(input [2:0] a);
  begin
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_rd(a < 3'h6 ? rg[a] : 16'h0000, reg_rdata);
  end
  endtask
  task set_ptr(input [3:0] wn, input [15:0] v);
  begin
    @(posedge sys_clk);
    set_en <= 1'b1;
    set_wn <= wn;
    set_val <= v;
    @(posedge sys_clk);
    set_en <= 1'b0;
    ptrs[wn] = v;
  end
  endtask
  function [15:0] rev16(input [15:0] v);
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1)
        rev16[k] = v[15 - k];
    end
  endfunction
  // Scoreboard request: expected answer worked out, then driven and compared
  task do_req(input dual, input wr, input byt, input [1:0] mode, input [3:0] wn,
    input [15:0] offs);
    reg [15:0] p, nv, ea, s, e, c;
    reg err, ysp, rev, cir, wbv, pw;
    integer o, a, n, len;
  begin
    p = ptrs[wn];
    c = rg[4];
    o = $signed(offs);
    a = o < 0 ? -o : o;
    err = dual && (wn < 8 || wn > 11 || mode == 2 || wr || (mode == 3 && !wn[0])
      || (mode == 1 && a != 2 && a != 4 && a != 6));
    // Space follows the pointer number even on a refused request
    ysp = dual && wn[3:1] == 3'h5;
    rev = !ysp && wr && !byt && wn == c[11:8] && c[11:8] != `DAG_SEL_OFF && rg[5][15]
      && (mode == 1 || mode == 2) && o > 0;
    s = ysp ? rg[2] : rg[0];
    e = ysp ? rg[3] : rg[1];
    cir = (ysp ? c[14] && c[7:4] == wn : c[15] && c[3:0] == wn) && wn != 4'hF && mode != 0;
    n = p + o;
    len = e - s + 1;
    // Power-of-two lengths check both bounds, others only the side of travel
    pw = (len & (len - 1)) == 0;
    if (cir && (o >= 0 || pw) && n > e)
      n = n - len;
    else if (cir && (o < 0 || pw) && n < s)
      n = n + len;
    nv = rev ? rev16(rev16(p) + rev16({rg[5][14:0], 1'b0})) & 16'hFFFE : n;
    ea = (mode < 2) ? p : nv;
    if ((rev && mode == 1) || ysp)
      ea = ea & 16'hFFFE;
    if (err)
      ea = 16'h0000;
    wbv = !err && (mode == 1 || mode == 2);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_dual <= dual;
    req_write <= wr;
    req_byte <= byt;
    req_mode <= mode;
    req_wn <= wn;
    req_offs <= offs;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1 chk(1'b1, ea_valid);
    chk(err, ea_error);
    chk(ysp, ea_space_y);
    chk(ea, ea_addr);
    chk(wbv, wb_valid);
    if (wbv)
    begin
      chk_wb(wn, wb_wn);
      chk_wb(nv, wb_value);
      ptrs[wn] = nv;
    end
  end
  endtask
  // Main sequence
  initial
  begin
    i = $urandom(32'h7ba7);
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
      rg[i] = 16'h0000;
    for (i = 0; i < 8; i = i + 1)
      rd_chk(i);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr_rd(i, $urandom);
    end
    // Power-of-two buffers: X on W4, Y on W10, reversal off
    wr_reg(`DAG_REG_X_CIRC_START, 16'h1000);
    wr_reg(`DAG_REG_X_CIRC_END, 16'h100F);
    wr_reg(`DAG_REG_Y_CIRC_START, 16'h2000);
    wr_reg(`DAG_REG_Y_CIRC_END, 16'h201F);
    wr_reg(`DAG_REG_REV_MODIFIER, 16'h0000);
    wr_reg(`DAG_REG_CIRC_REV_CTRL, 16'hC0A4);
    set_ptr(4, 16'h100E);
    do_req(0, 0, 0, 1, 4, 2);
    do_req(0, 0, 0, 2, 4, 16'hFFFE);
    set_ptr(4, 16'h100C);
    do_req(0, 0, 0, 1, 4, 6);
    do_req(0, 0, 0, 3, 4, 14);
    do_req(0, 0, 0, 0, 4, 2);
    set_ptr(10, 16'h201E);
    do_req(1, 0, 0, 1, 10, 2);
    set_ptr(11, 16'h2003);
    do_req(1, 0, 0, 0, 11, 0);
    set_ptr(9, 16'h0100);
    do_req(1, 0, 0, 3, 9, 16'h0010);
    do_req(1, 0, 0, 0, 4, 0);
    do_req(1, 0, 0, 3, 10, 0);
    do_req(1, 0, 0, 1, 9, 8);
    do_req(1, 0, 0, 2, 9, 2);
    do_req(1, 1, 0, 0, 9, 0);
    // Circular disabled by enable on X, by select and enable together on Y
    wr_reg(`DAG_REG_CIRC_REV_CTRL, 16'h40A4);
    set_ptr(4, 16'h100E);
    do_req(0, 0, 0, 1, 4, 2);
    wr_reg(`DAG_REG_CIRC_REV_CTRL, 16'h80F4);
    set_ptr(10, 16'h201E);
    do_req(1, 0, 0, 1, 10, 2);
    // Ten-byte buffer: only the side of travel is checked
    wr_reg(`DAG_REG_X_CIRC_END, 16'h1009);
    set_ptr(4, 16'h1008);
    do_req(0, 0, 0, 1, 4, 2);
    set_ptr(4, 16'h0FF0);
    do_req(0, 0, 0, 1, 4, 2);
    // Sixteen-byte buffer: both bounds are checked
    wr_reg(`DAG_REG_X_CIRC_END, 16'h100F);
    set_ptr(4, 16'h0FF0);
    do_req(0, 0, 0, 1, 4, 2);
    for (i = 0; i < 24; i = i + 1)
    begin
      set_ptr(i % 4, $urandom);
      do_req(0, $urandom, $urandom, $urandom, i % 4, ($urandom % 16) - 8);
    end
    // Reversal on W2, circular on W2 too so precedence shows
    wr_reg(`DAG_REG_X_CIRC_START, 16'h0000);
    wr_reg(`DAG_REG_X_CIRC_END, 16'h000F);
    wr_reg(`DAG_REG_REV_MODIFIER, 16'h8008);
    wr_reg(`DAG_REG_CIRC_REV_CTRL, 16'h82F2);
    set_ptr(2, 16'h0000);
    do_req(0, 1, 0, 1, 2, 2);
    do_req(0, 1, 0, 1, 2, 2);
    do_req(0, 1, 0, 2, 2, 2);
    set_ptr(2, 16'h000E);
    do_req(0, 1, 0, 1, 2, 2);
    do_req(0, 0, 0, 1, 2, 2);
    do_req(0, 1, 1, 1, 2, 1);
    do_req(0, 1, 0, 0, 2, 0);
    wr_reg(`DAG_REG_REV_MODIFIER, 16'h0008);
    do_req(0, 1, 0, 1, 2, 2);
    complete_run;
  end
endmodule
